/* File: hdl/mdu_pkg.sv */
// Constants, types and helpers shared by the muldiv_unit design.
// Assumes an 8-bit SFR bus with one-cycle read and write strobes.
package mdu_pkg;

    // ---------------------------------------------------------------
    // Register map and fields
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_MODE = 8'hAC;
    localparam logic [7:0] ADDR_CTRL = 8'hAD;
    localparam logic [7:0] ADDR_B0   = 8'hAE;
    localparam logic [7:0] ADDR_B1   = 8'hAF;
    localparam logic [7:0] ADDR_B2   = 8'hB1;
    localparam logic [7:0] ADDR_B3   = 8'hB2;
    localparam logic [7:0] ADDR_B4   = 8'hB3;
    localparam logic [7:0] ADDR_B5   = 8'hBA;
    localparam logic [7:0] MODE_RESET = 8'h10;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam int FINISH_BIT   = 4;
    localparam int UNSIGNED_BIT = 1;
    localparam int ERROR_BIT    = 7;
    localparam int OVERFLOW_BIT = 6;
    localparam int RIGHT_BIT    = 5;
    localparam logic [3:0] IDX_LAST_BYTE = 4'h5;
    localparam logic [3:0] IDX_MODE      = 4'h6;
    localparam logic [3:0] IDX_CTRL      = 4'h7;
    localparam logic [3:0] IDX_NONE      = 4'hF;

    // ---------------------------------------------------------------
    // Execution times in clock cycles
    // ---------------------------------------------------------------
    localparam logic [4:0] DIV32_CYCLES = 5'h11;
    localparam logic [4:0] DIV16_CYCLES = 5'h09;
    localparam logic [4:0] MUL_CYCLES   = 5'h0B;
    localparam logic [4:0] SHIFT_BASE   = 5'h02;
    localparam logic [4:0] NORM_BASE    = 5'h03;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_EXEC = 2'h1,
        ST_DONE = 2'h3
    } fsm_t;

    typedef enum logic [2:0] {
        OP_NONE  = 3'h0,
        OP_DIV32 = 3'h1,
        OP_DIV16 = 3'h2,
        OP_MUL   = 3'h3,
        OP_SHIFT = 3'h4,
        OP_NORM  = 3'h5
    } op_t;

    typedef enum logic [3:0] {
        SQ_IDLE = 4'h0, SQ_B0 = 4'h1, SQ_B01 = 4'h2, SQ_B012 = 4'h3,
        SQ_B0123 = 4'h4, SQ_B01234 = 4'h5, SQ_B014 = 4'h6,
        SQ_B04 = 4'h7, SQ_B041 = 4'h8
    } seq_t;

    typedef logic [5:0][7:0] md_bank_t;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } sfr_req_t;

    // Cycles an operation takes; shifts move two bits per cycle.
    function automatic logic [4:0] op_cycles(input op_t op, input logic [4:0] cnt,
                                             input logic [4:0] done);
        case (op)
            OP_DIV32: op_cycles = DIV32_CYCLES;
            OP_DIV16: op_cycles = DIV16_CYCLES;
            OP_MUL:   op_cycles = MUL_CYCLES;
            OP_SHIFT: op_cycles = SHIFT_BASE + 5'((6'(cnt) + 6'h01) >> 1);
            OP_NORM:  op_cycles = NORM_BASE + 5'((6'(done) + 6'h02) >> 1);
            default:  op_cycles = 5'h01;
        endcase
    endfunction : op_cycles

endpackage : mdu_pkg

/* File: hdl/mdu_arith.sv */
// Combinational arithmetic core of the muldiv_unit.
// Assumes the caller holds operands stable and applies results later.
`timescale 1ns/10ps
`default_nettype none
module mdu_arith
    import mdu_pkg::*;
(
    input  wire op_t        op,
    input  wire logic       uns,
    input  wire md_bank_t   md,
    input  wire logic       right,
    input  wire logic [4:0] count,
    output md_bank_t        res,
    output logic            ovf,
    output logic [4:0]      shifts
);

    logic [31:0] v;
    logic [15:0] dsr;
    logic [31:0] q;
    logic [31:0] r;
    logic [31:0] p;
    logic [5:0]  lz;

    // ---------------------------------------------------------------
    // One result per operation, written back over the operands
    // ---------------------------------------------------------------
    always_comb begin
        v = {md[3], md[2], md[1], md[0]};
        dsr = {md[5], md[4]};
        q = 32'h0;
        r = 32'h0;
        p = 32'h0;
        lz = 6'h00;
        res = md;
        ovf = 1'b0;
        shifts = 5'h00;
        case (op)
            OP_DIV32, OP_DIV16: begin
                if (op == OP_DIV16) begin
                    v = uns ? {16'h0, v[15:0]} : {{16{v[15]}}, v[15:0]};
                end
                if (dsr == 16'h0) begin
                    ovf = 1'b1;
                end else if (uns) begin
                    q = v / {16'h0, dsr};
                    r = v % {16'h0, dsr};
                end else begin
                    q = 32'($signed(v) / $signed({{16{dsr[15]}}, dsr}));
                    r = 32'($signed(v) % $signed({{16{dsr[15]}}, dsr}));
                end
                // Quotient from byte0 up, remainder in bytes 4 and 5.
                res[0] = q[7:0];
                res[1] = q[15:8];
                if (op == OP_DIV32) begin
                    res[2] = q[23:16];
                    res[3] = q[31:24];
                end
                res[4] = r[7:0];
                res[5] = r[15:8];
                if (dsr == 16'h0) begin
                    res = md;
                end
            end
            OP_MUL: begin
                if (uns) begin
                    p = {16'h0, v[15:0]} * {16'h0, dsr};
                    ovf = p[31:16] != 16'h0;
                end else begin
                    p = 32'($signed({{16{v[15]}}, v[15:0]}) * $signed({{16{dsr[15]}}, dsr}));
                    ovf = p[31:15] != {17{p[31]}};
                end
                {res[3], res[2], res[1], res[0]} = p;
            end
            OP_SHIFT: begin
                // Logical shifts: zeros fill whichever end is vacated.
                {res[3], res[2], res[1], res[0]} = right ? v >> count : v << count;
            end
            OP_NORM: begin
                for (int i = 31; i >= 0; i--) begin
                    if (lz == 6'(31 - i) && !v[i]) begin
                        lz = lz + 6'h01;
                    end
                end
                // An all-zero value stops at the widest count the field can hold.
                shifts = (lz > 6'h1F) ? 5'h1F : lz[4:0];
                ovf = v[31];
                {res[3], res[2], res[1], res[0]} = v << shifts;
            end
            default: begin
                res = md;
            end
        endcase
    end

endmodule : mdu_arith
`default_nettype wire

/* File: hdl/muldiv_unit.sv */
// Top of the muldiv_unit: SFR decode, load sequencer, timing and flags.
// Assumes one-cycle SFR strobes synchronous to clk; reads answer one edge later.
`timescale 1ns/10ps
`default_nettype none
module muldiv_unit
    import mdu_pkg::*;
(
    input  wire logic     clk,
    input  wire logic     sys_rst,
    input  wire sfr_req_t sfrReq,
    output logic [7:0]    sfrReadData,
    output logic          sfrReadHit
);

    typedef struct packed {
        fsm_t       fsm;
        seq_t       seq;
        op_t        op;
        logic [4:0] cnt;
        logic       armed;
        logic       uns;
        logic       fin;
        logic       err;
        logic       ovf;
        logic       right;
        logic [4:0] count;
        md_bank_t   md;
        md_bank_t   res;
        logic [4:0] resShift;
        logic [7:0] rdata;
        logic       rhit;
    } mdu_state_t;

    mdu_state_t cur;
    mdu_state_t next_cur;

    // ---------------------------------------------------------------
    // Helper functions
    // ---------------------------------------------------------------

    // Maps an SFR address onto a register index.
    function automatic logic [3:0] addr_index(input logic [7:0] a);
        if (a == ADDR_B0) begin
            addr_index = 4'h0;
        end else if (a == ADDR_B1) begin
            addr_index = 4'h1;
        end else if (a == ADDR_B2) begin
            addr_index = 4'h2;
        end else if (a == ADDR_B3) begin
            addr_index = 4'h3;
        end else if (a == ADDR_B4) begin
            addr_index = 4'h4;
        end else if (a == ADDR_B5) begin
            addr_index = 4'h5;
        end else if (a == ADDR_MODE) begin
            addr_index = IDX_MODE;
        end else if (a == ADDR_CTRL) begin
            addr_index = IDX_CTRL;
        end else begin
            addr_index = IDX_NONE;
        end
    endfunction : addr_index

    // Stores a written byte into the operand bank.
    function automatic md_bank_t merge(input md_bank_t m, input logic [3:0] i,
                                       input logic w, input logic [7:0] d);
        merge = m;
        if (w && i <= IDX_LAST_BYTE) begin
            merge[i[2:0]] = d;
        end
    endfunction : merge

    // Follows the write order; anything off the table but a mode or unmapped write drops the sequence.
    function automatic seq_t next_seq(input seq_t s, input logic [3:0] i);
        next_seq = SQ_IDLE;
        case (i)
            4'h0: next_seq = SQ_B0;
            4'h1: begin
                if (s == SQ_B0) begin
                    next_seq = SQ_B01;
                end else if (s == SQ_B04) begin
                    next_seq = SQ_B041;
                end
            end
            4'h2: next_seq = (s == SQ_B01) ? SQ_B012 : SQ_IDLE;
            4'h3: next_seq = (s == SQ_B012) ? SQ_B0123 : SQ_IDLE;
            4'h4: begin
                if (s == SQ_B01) begin
                    next_seq = SQ_B014;
                end else if (s == SQ_B0123) begin
                    next_seq = SQ_B01234;
                end else if (s == SQ_B0) begin
                    next_seq = SQ_B04;
                end
            end
            IDX_MODE, IDX_NONE: next_seq = s;
            default: next_seq = SQ_IDLE;
        endcase
    endfunction : next_seq

    // Operation started by this write, if any.
    function automatic op_t start_op(input seq_t s, input logic [3:0] i,
                                     input logic w, input logic cz);
        start_op = OP_NONE;
        if (w && i == IDX_CTRL) begin
            start_op = cz ? OP_NORM : OP_SHIFT;
        end else if (w && i == 4'h5) begin
            if (s == SQ_B01234) begin
                start_op = OP_DIV32;
            end else if (s == SQ_B014) begin
                start_op = OP_DIV16;
            end else if (s == SQ_B041) begin
                start_op = OP_MUL;
            end
        end
    endfunction : start_op

    // ---------------------------------------------------------------
    // Access decode and operands as they stand after this write
    // ---------------------------------------------------------------
    logic [3:0] idx;
    logic       ctrlWr;
    logic       wrMd;
    logic       rdMd;
    logic       ctrlRd;
    logic       errSet;
    logic       finalRd;
    md_bank_t   mdIn;
    logic [4:0] cntIn;
    logic       rightIn;
    logic       unsIn;
    op_t        startOp;
    md_bank_t   engRes;
    logic       engOvf;
    logic [4:0] engShifts;

    // Decoded strobes used by the sequencer and the flags.
    assign idx = addr_index(sfrReq.addr);
    assign ctrlWr = sfrReq.wr && idx == IDX_CTRL;
    assign wrMd = sfrReq.wr && (idx <= IDX_LAST_BYTE || idx == IDX_CTRL);
    assign rdMd = sfrReq.rd && idx <= IDX_LAST_BYTE;
    assign ctrlRd = sfrReq.rd && idx == IDX_CTRL;
    assign errSet = cur.fsm == ST_EXEC && (wrMd || (rdMd && cur.armed));
    assign finalRd = sfrReq.rd && cur.fsm != ST_EXEC && cur.armed
                     && ((idx == 4'h5) == (cur.op == OP_DIV32 || cur.op == OP_DIV16))
                     && (idx == 4'h5 || idx == 4'h3);

    // The starting write itself feeds the core, so no cycle is lost.
    assign mdIn = merge(cur.md, idx, sfrReq.wr, sfrReq.wdata);
    assign cntIn = ctrlWr ? sfrReq.wdata[4:0] : cur.count;
    assign rightIn = ctrlWr ? sfrReq.wdata[RIGHT_BIT] : cur.right;
    assign unsIn = (sfrReq.wr && idx == IDX_MODE) ? sfrReq.wdata[UNSIGNED_BIT] : cur.uns;
    assign startOp = start_op(cur.seq, idx, sfrReq.wr, cntIn == 5'h00);

    mdu_arith u_arith (
        .op     (startOp),
        .uns    (unsIn),
        .md     (mdIn),
        .right  (rightIn),
        .count  (cntIn),
        .res    (engRes),
        .ovf    (engOvf),
        .shifts (engShifts)
    );

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    // The result is computed at start and held back until the counted
    // time has passed, which keeps the core combinational but the
    // visible timing exact.
    always_comb begin
        next_cur = cur;
        if (cur.fsm == ST_EXEC) begin
            if (cur.cnt == 5'h00) begin
                next_cur.fsm = ST_DONE;
                next_cur.fin = 1'b1;
                next_cur.md = cur.res;
                if (cur.op == OP_NORM) begin
                    next_cur.count = cur.resShift;
                end
            end else begin
                next_cur.cnt = cur.cnt - 5'h01;
            end
        end
        next_cur.md = merge(next_cur.md, idx, sfrReq.wr, sfrReq.wdata);
        if (ctrlWr) begin
            next_cur.right = sfrReq.wdata[RIGHT_BIT];
            next_cur.count = sfrReq.wdata[4:0];
        end
        if (sfrReq.wr && idx == IDX_MODE) begin
            next_cur.uns = sfrReq.wdata[UNSIGNED_BIT];
        end
        // A byte or control write while busy abandons the running calculation.
        if (wrMd && cur.fsm == ST_EXEC) begin
            next_cur.fsm = ST_IDLE;
            next_cur.fin = 1'b0;
        end
        if (sfrReq.wr) begin
            next_cur.seq = next_seq(cur.seq, idx);
            if (idx == 4'h0) begin
                next_cur.armed = 1'b1;
            end
        end
        if (startOp != OP_NONE) begin
            next_cur.fsm = ST_EXEC;
            next_cur.fin = 1'b0;
            next_cur.op = startOp;
            next_cur.cnt = op_cycles(startOp, cntIn, engShifts) - 5'h01;
            next_cur.res = engRes;
            next_cur.resShift = engShifts;
            next_cur.ovf = engOvf;
            next_cur.seq = SQ_IDLE;
        end
        if (finalRd) begin
            next_cur.armed = 1'b0;
            next_cur.fsm = ST_IDLE;
        end
        // Setting wins over the clearing read in the same cycle.
        next_cur.err = errSet | (cur.err & ~ctrlRd);
        next_cur.rhit = sfrReq.rd && idx != IDX_NONE;
        next_cur.rdata = 8'h00;
        if (sfrReq.rd) begin
            if (idx <= IDX_LAST_BYTE) begin
                next_cur.rdata = cur.md[idx[2:0]];
            end else if (idx == IDX_MODE) begin
                next_cur.rdata = {3'h0, cur.fin, 2'h0, cur.uns, 1'b0};
            end else if (idx == IDX_CTRL) begin
                next_cur.rdata = {cur.err, cur.ovf, cur.right, cur.count};
            end
        end
    end

    // ---------------------------------------------------------------
    // State register
    // ---------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cur <= '0;
            cur.fsm <= ST_IDLE;
            cur.seq <= SQ_IDLE;
            cur.op <= OP_NONE;
            cur.fin <= MODE_RESET[FINISH_BIT];
            cur.uns <= MODE_RESET[UNSIGNED_BIT];
            cur.err <= CTRL_RESET[ERROR_BIT];
            cur.ovf <= CTRL_RESET[OVERFLOW_BIT];
            cur.right <= CTRL_RESET[RIGHT_BIT];
            cur.count <= CTRL_RESET[4:0];
            cur.md <= {6{BYTE_RESET}};
        end else begin
            cur <= next_cur;
        end
    end

    // Bus answers leave straight from flip-flops.
    assign sfrReadData = cur.rdata;
    assign sfrReadHit = cur.rhit;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    logic [4:0] elapsed;

    // Counts edges spent executing since the last start.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            elapsed <= 5'h00;
        end else if (startOp != OP_NONE) begin
            elapsed <= 5'h00;
        end else if (cur.fsm == ST_EXEC) begin
            elapsed <= elapsed + 5'h01;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_finish(op_t o);
        $rose(cur.fin) && cur.op == o;
    endsequence

    sequence s_busy_write;
        cur.fsm == ST_EXEC && wrMd;
    endsequence

    a_finish_low_busy: assert property (cur.fsm == ST_EXEC |-> !cur.fin)
        else $error("finish flag high while executing");
    a_div32_time: assert property (s_finish(OP_DIV32) |-> elapsed == 5'h11)
        else $error("32/16 division took wrong cycle count");
    a_div16_time: assert property (s_finish(OP_DIV16) |-> elapsed == 5'h09)
        else $error("16/16 division took wrong cycle count");
    a_mul_time: assert property (s_finish(OP_MUL) |-> elapsed == 5'h0B)
        else $error("multiplication took wrong cycle count");
    a_shift_time: assert property (s_finish(OP_SHIFT) |->
            elapsed == op_cycles(OP_SHIFT, cur.count, 5'h00))
        else $error("shift took wrong cycle count");
    a_norm_time: assert property (s_finish(OP_NORM) |->
            elapsed == op_cycles(OP_NORM, 5'h00, cur.count))
        else $error("normalize took wrong cycle count");
    a_busy_write_err: assert property (s_busy_write |=> cur.err ##1 cur.err || $past(ctrlRd))
        else $error("write during execution did not set error flag");
    a_read_keeps_run: assert property (cur.fsm == ST_EXEC && cur.armed && rdMd && !wrMd
            |=> cur.err && cur.fsm != ST_IDLE)
        else $error("armed read during execution mishandled");
    a_err_sticky: assert property (cur.err && !ctrlRd |=> cur.err)
        else $error("error flag cleared without control read");
    a_err_read_clr: assert property (cur.err && ctrlRd && !errSet |=> !cur.err)
        else $error("control read did not clear error flag");
    a_ovf_only_start: assert property (!$stable(cur.ovf) |-> $past(startOp != OP_NONE))
        else $error("overflow flag changed without a start");
    a_norm_msb_set: assert property (s_finish(OP_NORM) && cur.md[3:0] != 32'h0
            |-> cur.md[3][7])
        else $error("normalize left top bit clear");

endmodule : muldiv_unit
`default_nettype wire

/* File: verif/host_core_model.sv */
// Host core model: issues one-cycle SFR writes and reads to the unit.
// Assumes callers enter its tasks just after a falling clock edge.
`timescale 1ns/10ps
`default_nettype none
module host_core_model
    import mdu_pkg::*;
(
    input  wire logic       clk,
    input  wire logic [7:0] readData,
    input  wire logic       readHit,
    output var sfr_req_t    req
);
    // ---------------------------------------------------------------
    // Bus cycles
    // ---------------------------------------------------------------
    // Idle address and data are inverted so a stale value never looks valid.
    initial begin
        req = '0;
    end

    // One write strobe, held across exactly one rising edge and released on
    // that edge, so a following call never drives the bus twice in one step.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req = {a, 1'b1, 1'b0, d};
        @(posedge clk);
        req <= {~a, 1'b0, 1'b0, ~d};
        @(negedge clk);
    endtask : wr

    // The answer stands in the cycle after the strobe edge.
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic h);
        req = {a, 1'b0, 1'b1, 8'h00};
        @(posedge clk);
        req <= {~a, 1'b0, 1'b0, 8'hFF};
        @(negedge clk);
        d = readData;
        h = readHit;
    endtask : rd
endmodule : host_core_model
`default_nettype wire

/* File: verif/test_muldiv_unit.sv */
// Self-checking bench for muldiv_unit, one task per scenario.
// Assumes the host model drives the SFR bus on falling clock edges.
`timescale 1ns/10ps
`default_nettype none
module test_muldiv_unit
    import mdu_pkg::*;
;
    localparam logic [7:0] ADR [6] = '{ADDR_B0, ADDR_B1, ADDR_B2, ADDR_B3, ADDR_B4, ADDR_B5};
    logic       clk = 1'b0;
    logic       sys_rst = 1'b1;
    sfr_req_t   sfrReq;
    logic [7:0] sfrReadData;
    logic       sfrReadHit;
    int         mismatches = 0;
    int         cmp_count = 0;

    // ---------------------------------------------------------------
    // Clock, design and host
    // ---------------------------------------------------------------
    // Half period of 5 ns gives 100 MHz.
    always #5 clk = ~clk;
    muldiv_unit muldiv_unit_i (.clk(clk), .sys_rst(sys_rst), .sfrReq(sfrReq),
        .sfrReadData(sfrReadData), .sfrReadHit(sfrReadHit));
    host_core_model host_core_model_i (.clk(clk), .readData(sfrReadData),
        .readHit(sfrReadHit), .req(sfrReq));

    task automatic put(input logic [7:0] a, input logic [7:0] d);
        host_core_model_i.wr(a, d);
    endtask : put

    // Read a mapped register and compare the bits selected by the mask.
    task automatic chk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
        logic [7:0] d;
        logic       h;
        host_core_model_i.rd(a, d, h);
        cmp_count++;
        if ((d & m) !== (e & m) || h !== 1'b1) begin
            $display("ERROR %0t addr %h read %h want %h", $time, a, d, e);
            mismatches++;
        end
    endtask : chk

    // Finish must be low one edge before the count and high one edge after.
    task automatic tim(input int n);
        repeat (n - 2) @(negedge clk);
        chk(ADDR_MODE, 8'h00, 8'h10);
        @(negedge clk);
        chk(ADDR_MODE, 8'h10, 8'h10);
    endtask : tim

    task automatic res(input logic [5:0] sel, input logic [47:0] v);
        for (int i = 0; i < 6; i++) begin
            if (sel[i]) begin
                chk(ADR[i], v[8*i +: 8]);
            end
        end
    endtask : res

    task automatic reset_values();
        logic [7:0] d;
        logic       h;
        chk(ADDR_MODE, 8'h10);
        chk(ADDR_CTRL, 8'h00);
        res(6'h3F, 48'h0);
        host_core_model_i.rd(8'h00, d, h);
        cmp_count++;
        if (d !== 8'h00 || h !== 1'b0) begin
            $display("ERROR %0t unmapped read answered", $time);
            mismatches++;
        end
    endtask : reset_values

    // Unsigned product, then a right shift started without rearming.
    task automatic mul_then_shift();
        put(ADDR_MODE, 8'h02);
        put(ADDR_B0, 8'hFF);
        put(ADDR_B4, 8'h01);
        put(ADDR_B1, 8'h00);
        put(ADDR_B5, 8'h01);
        tim(11);
        chk(ADDR_CTRL, 8'h00, 8'hC0);
        res(6'h0F, 48'h0000FFFF);
        put(ADDR_CTRL, 8'h24);
        chk(ADDR_B0, 8'h00, 8'h00);
        tim(3);
        res(6'h0F, 48'h00000FFF);
        chk(ADDR_CTRL, 8'h20, 8'hE0);
    endtask : mul_then_shift

    task automatic divisions();
        put(ADDR_B0, 8'h45);
        put(ADDR_B1, 8'h23);
        put(ADDR_B2, 8'h01);
        put(ADDR_B3, 8'h00);
        put(ADDR_B4, 8'h10);
        put(ADDR_B5, 8'h00);
        tim(17);
        res(6'h3F, 48'h000500001234);
        put(ADDR_MODE, 8'h00);
        put(ADDR_B0, 8'hF9);
        put(ADDR_B1, 8'hFF);
        put(ADDR_B4, 8'h02);
        put(ADDR_B5, 8'h00);
        tim(9);
        res(6'h33, 48'hFFFF0000FFFD);
        put(ADDR_B0, 8'h05);
        put(ADDR_B1, 8'h00);
        put(ADDR_B4, 8'h00);
        put(ADDR_B5, 8'h00);
        tim(9);
        chk(ADDR_CTRL, 8'h40, 8'h40);
        chk(ADDR_B5, 8'h00);
    endtask : divisions

    task automatic shift_and_normalize();
        put(ADDR_B0, 8'h01);
        put(ADDR_B1, 8'h00);
        put(ADDR_B2, 8'h00);
        put(ADDR_B3, 8'h00);
        put(ADDR_CTRL, 8'h1F);
        tim(18);
        res(6'h0F, 48'h80000000);
        put(ADDR_CTRL, 8'h00);
        tim(4);
        chk(ADDR_CTRL, 8'h40, 8'hDF);
        put(ADDR_B0, 8'h00);
        put(ADDR_B1, 8'h01);
        put(ADDR_B2, 8'h00);
        put(ADDR_B3, 8'h00);
        put(ADDR_CTRL, 8'h00);
        tim(15);
        chk(ADDR_CTRL, 8'h17, 8'hDF);
        res(6'h0F, 48'h80000000);
    endtask : shift_and_normalize

    // An armed byte read while busy flags an error; a busy write flags and aborts.
    task automatic busy_access();
        put(ADDR_B0, 8'h03);
        put(ADDR_B4, 8'h04);
        put(ADDR_B1, 8'h00);
        put(ADDR_B5, 8'h00);
        chk(ADDR_B0, 8'h03, 8'h00);
        chk(ADDR_CTRL, 8'h80, 8'h80);
        chk(ADDR_CTRL, 8'h00, 8'h80);
        put(ADDR_B0, 8'h07);
        chk(ADDR_CTRL, 8'h80, 8'h80);
        repeat (12) @(negedge clk);
        chk(ADDR_MODE, 8'h00, 8'h10);
    endtask : busy_access

    task automatic tally_and_finish();
        $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (8) @(negedge clk);
        sys_rst = 1'b0;
        reset_values();
        mul_then_shift();
        divisions();
        shift_and_normalize();
        busy_access();
        tally_and_finish();
    end
endmodule : test_muldiv_unit
`default_nettype wire
